// [hw/spi_port.sv]
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_port (
  input  wire logic        pclk,           // Core clock, 100 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        clk_en,         // Freezes all state when low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [31:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        sclk_in,        // Serial clock pin level
  output logic             sclk_out,       // Serial clock drive value
  output logic             sclk_oe,        // Serial clock drive enable
  input  wire logic        mosi_in,        // MOSI pin level
  output logic             mosi_out,       // MOSI drive value
  output logic             mosi_oe,        // MOSI drive enable
  input  wire logic        miso_in,        // MISO pin level
  output logic             miso_out,       // MISO drive value
  output logic             miso_oe,        // MISO drive enable
  input  wire logic        cs_pin_n_in,    // Select pin level
  output logic             cs_pin_n_out,   // Select drive value
  output logic             cs_pin_n_oe     // Select drive enable
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [15:0]                     ctrl_ff;      // Control register
  logic [5:0]                      div_ff;       // Bit rate divider
  spi_port_pkg::byte_type          tx_mem [4];   // Transmit storage
  spi_port_pkg::byte_type          rx_mem [4];   // Receive storage
  logic [1:0]                      tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [2:0]                      tx_cnt_ff, rx_cnt_ff;  // Occupancy
  logic                            pready_ff, pslverr_ff;
  logic [31:0]                     prdata_ff;
  logic                            rx_valid_ff;  // Read captured a byte
  logic                            ovf_ff, rxirq_ff, txirq_ff, uf_ff, pend_ff;
  logic [1:0]                      sent_ff;      // Bytes sent since irq
  spi_port_pkg::master_state_type  m_state_ff;
  logic [5:0]                      half_ff;      // Half period counter
  logic [4:0]                      edge_ff;      // Edges in byte
  logic                            sclk_ff, cs_n_ff, go_on_ff, start_req_ff;
  logic                            sclk_q_ff, cs_q_ff; // Previous pin levels
  spi_port_pkg::byte_type          tx_sr_ff, rx_sr_ff;
  logic [2:0]                      bit_ff;       // Sampled bits
  logic                            first_ff, reload_ff;
  logic                            sclk_oe_ff, mosi_ff, mosi_oe_ff;
  logic                            miso_ff, miso_oe_ff, cs_oe_ff;
  logic [31:0]                     rd_mux;       // Read data at setup
  logic                            hit;          // Address decodes
  logic                            en, master, cpha, cpol, tmode, rxfl, txfl;
  logic [1:0]                      thr;
  logic                            wr_acc, rd_acc, st_rd, rx_rd, tx_wr;
  logic                            tick, lead_ev, trail_ev, sample_ev, shift_ev;
  logic                            start, load, tx_avail, in_bit, byte_done;
  logic                            s_act, s_rise, s_fall, rx_push, tx_push;
  logic                            ovf_set, rxirq_set, txirq_set, uf_set, pend_set;
  logic [2:0]                      rx_ovw;       // Overwrite slot index

  assign en     = ctrl_ff[`CTL_ENABLE];
  assign master = ctrl_ff[`CTL_MASTER];
  assign cpha   = ctrl_ff[`CTL_CPHA];
  assign cpol   = ctrl_ff[`CTL_CPOL];
  assign tmode  = ctrl_ff[`CTL_TMODE];
  assign rxfl   = ctrl_ff[`CTL_RX_FLUSH];
  assign txfl   = ctrl_ff[`CTL_TX_FLUSH];
  assign thr    = ctrl_ff[`CTL_THR_HI:`CTL_THR_LO];
  assign rx_ovw = {1'b0, rx_wp_ff - 2'h1};

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  // Read mux evaluated in the setup cycle
  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == `ADDR_STATUS)
      rd_mux = {20'h0_0000, (rx_cnt_ff > {1'b0, thr} + 3'h1), rx_cnt_ff,
                ovf_ff, rxirq_ff, txirq_ff, uf_ff, tx_cnt_ff, pend_ff};
    else if (paddr == `ADDR_RXDATA)
      rd_mux = {24'h00_0000, (rx_cnt_ff != 3'h0) ? rx_mem[rx_rp_ff] : `BYTE_ZERO};
    else if (paddr == `ADDR_TXDATA)
      rd_mux = 32'h0000_0000;   // Write only, reads zero
    else if (paddr == `ADDR_DIVIDER)
      rd_mux = {26'h000_0000, div_ff};
    else if (paddr == `ADDR_CONTROL)
      rd_mux = {16'h0000, ctrl_ff};
    else
      hit = 1'b0;
  end

  assign wr_acc = psel && penable && pready_ff && pwrite;
  assign rd_acc = psel && penable && pready_ff && !pwrite;
  assign st_rd  = rd_acc && (paddr == `ADDR_STATUS);
  assign rx_rd  = rd_acc && (paddr == `ADDR_RXDATA) && rx_valid_ff;
  // Writes during transmit flush are dropped
  assign tx_wr  = wr_acc && (paddr == `ADDR_TXDATA) && !txfl;

  // No wait state: answer is registered at setup, taken next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      prdata_ff   <= 32'h0000_0000;
      rx_valid_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel && !penable)
      begin
        pready_ff   <= 1'b1;
        pslverr_ff  <= !hit;
        prdata_ff   <= pwrite ? 32'h0000_0000 : rd_mux;
        rx_valid_ff <= (rx_cnt_ff != 3'h0);
      end
      else
      begin
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Control and divider registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= `CONTROL_RST;
      div_ff  <= `DIVIDER_RST;
    end
    else if (clk_en && wr_acc)
    begin
      if (paddr == `ADDR_CONTROL)
        ctrl_ff <= pwdata[15:0];
      else if (paddr == `ADDR_DIVIDER)
        div_ff <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------
  // Serial clock events
  // ----------------------------------------------------------
  // Half period is div+1 core cycles, so SCLK = pclk / (2(1+div))
  assign tick     = (half_ff == div_ff);
  assign s_act    = en && !master && !cs_pin_n_in;
  assign s_rise   = sclk_in && !sclk_q_ff;
  assign s_fall   = !sclk_in && sclk_q_ff;
  // Leading edge leaves the idle level, trailing returns to it
  assign lead_ev  = master ? (m_state_ff == spi_port_pkg::M_RUN && tick && sclk_ff == cpol)
                           : (s_act && (cpol ? s_fall : s_rise));
  assign trail_ev = master ? (m_state_ff == spi_port_pkg::M_RUN && tick && sclk_ff != cpol)
                           : (s_act && (cpol ? s_rise : s_fall));
  assign sample_ev = cpha ? trail_ev : lead_ev;
  assign shift_ev  = cpha ? lead_ev : trail_ev;
  assign tx_avail  = (tx_cnt_ff != 3'h0) && !txfl;
  // Master start: FIFO data in transmit mode, a data read otherwise
  assign start = en && master && m_state_ff == spi_port_pkg::M_IDLE &&
                 (tmode ? tx_avail : start_req_ff);
  assign load  = start || (!master && cs_q_ff && !cs_pin_n_in && en) ||
                 (shift_ev && reload_ff);
  // Loopback ties the master input to its own output
  assign in_bit = master ? (ctrl_ff[`CTL_LOOPBACK] ? tx_sr_ff[7] : miso_in)
                         : mosi_in;
  assign byte_done = sample_ev && (bit_ff == `BIT_LAST);

  // Pin history for slave edge and select detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
    end
    else if (clk_en)
    begin
      sclk_q_ff <= sclk_in;
      cs_q_ff   <= cs_pin_n_in;
    end
  end

  // ----------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------
  // Read of receive data requests a master transfer in read mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_req_ff <= 1'b0;
    else if (clk_en)
    begin
      if (start)
        start_req_ff <= 1'b0;
      else if (rd_acc && paddr == `ADDR_RXDATA && !tmode)
        start_req_ff <= 1'b1;
    end
  end

  // Select low, lead half, sixteen edges, tail half, one-period stall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_state_ff <= spi_port_pkg::M_IDLE;
      half_ff    <= 6'h00;
      edge_ff    <= 5'h00;
      sclk_ff    <= 1'b0;
      cs_n_ff    <= 1'b1;
    end
    else if (clk_en)
    begin
      half_ff <= (tick || m_state_ff == spi_port_pkg::M_IDLE) ? 6'h00 : half_ff + 6'h01;
      case (m_state_ff)
        spi_port_pkg::M_IDLE:
        begin
          sclk_ff <= cpol;
          if (start)
          begin
            cs_n_ff    <= 1'b0;
            m_state_ff <= spi_port_pkg::M_LEAD;
          end
        end
        spi_port_pkg::M_LEAD:
          if (tick)
          begin
            edge_ff    <= 5'h00;
            m_state_ff <= spi_port_pkg::M_RUN;
          end
        spi_port_pkg::M_RUN:
          if (tick)
          begin
            sclk_ff <= !sclk_ff;
            edge_ff <= edge_ff + 5'h01;
            // Sixteen edges make eight periods per byte
            if (edge_ff == `EDGE_LAST)
              m_state_ff <= spi_port_pkg::M_TAIL;
          end
        spi_port_pkg::M_TAIL:
          if (tick)
          begin
            edge_ff <= 5'h00;
            if (go_on_ff)
              m_state_ff <= spi_port_pkg::M_RUN;
            else
            begin
              cs_n_ff    <= 1'b1;
              m_state_ff <= spi_port_pkg::M_STALL;
            end
          end
        spi_port_pkg::M_STALL:
          if (tick)
          begin
            edge_ff <= edge_ff + 5'h01;
            if (edge_ff == `STALL_LAST)
              m_state_ff <= spi_port_pkg::M_IDLE;
          end
        default:
          m_state_ff <= spi_port_pkg::M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Shift registers
  // ----------------------------------------------------------
  // Separate launch and capture registers keep the output bit steady
  // until its own launch edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_sr_ff  <= `BYTE_ZERO;
      rx_sr_ff  <= `BYTE_ZERO;
      bit_ff    <= 3'h0;
      first_ff  <= 1'b0;
      reload_ff <= 1'b0;
      go_on_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        // Empty or flushed FIFO sends zeros
        tx_sr_ff  <= tx_avail ? tx_mem[tx_rp_ff] : `BYTE_ZERO;
        first_ff  <= (start || !reload_ff) ? cpha : 1'b0;
        reload_ff <= 1'b0;
        if (!reload_ff)
          bit_ff <= 3'h0;
      end
      else if (shift_ev)
      begin
        if (first_ff)
          first_ff <= 1'b0;
        else
          tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
      end
      if (sample_ev)
      begin
        rx_sr_ff <= {rx_sr_ff[6:0], in_bit};
        bit_ff   <= bit_ff + 3'h1;
      end
      if (byte_done)
      begin
        // Slave keeps going while selected; master only when allowed
        reload_ff <= !master || (ctrl_ff[`CTL_CONTINUOUS] && tx_avail);
        go_on_ff  <= master && ctrl_ff[`CTL_CONTINUOUS] && tx_avail;
      end
      if (!master && cs_pin_n_in)
        reload_ff <= 1'b0;
      if (start)
        go_on_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------
  assign tx_push = tx_wr && (tx_cnt_ff != `FIFO_FULL);
  assign rx_push = byte_done && !rxfl;

  // Transmit queue: data write pushes, byte load pops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_ff  <= 2'h0;
      tx_rp_ff  <= 2'h0;
      tx_cnt_ff <= 3'h0;
      for (int i = 0; i < 4; i++)
        tx_mem[i] <= `BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (txfl)
      begin
        tx_rp_ff  <= tx_wp_ff;
        tx_cnt_ff <= 3'h0;
      end
      else
      begin
        if (tx_push)
        begin
          tx_mem[tx_wp_ff] <= pwdata[7:0];
          tx_wp_ff         <= tx_wp_ff + 2'h1;
        end
        if (load && tx_avail)
          tx_rp_ff <= tx_rp_ff + 2'h1;
        tx_cnt_ff <= tx_cnt_ff + {2'h0, tx_push} - {2'h0, load && tx_avail};
      end
    end
  end

  // Receive queue: full FIFO drops or overwrites the newest byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp_ff  <= 2'h0;
      rx_rp_ff  <= 2'h0;
      rx_cnt_ff <= 3'h0;
      for (int i = 0; i < 4; i++)
        rx_mem[i] <= `BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (rxfl)
      begin
        rx_rp_ff  <= rx_wp_ff;
        rx_cnt_ff <= 3'h0;
      end
      else
      begin
        if (rx_push && rx_cnt_ff != `FIFO_FULL)
        begin
          rx_mem[rx_wp_ff] <= {rx_sr_ff[6:0], in_bit};
          rx_wp_ff         <= rx_wp_ff + 2'h1;
        end
        else if (rx_push && ctrl_ff[`CTL_OVERWRITE] && !rx_rd)
          rx_mem[rx_ovw[1:0]] <= {rx_sr_ff[6:0], in_bit};
        if (rx_rd)
          rx_rp_ff <= rx_rp_ff + 2'h1;
        rx_cnt_ff <= rx_cnt_ff + {2'h0, rx_push && rx_cnt_ff != `FIFO_FULL}
                     - {2'h0, rx_rd};
      end
    end
  end

  // ----------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------
  assign ovf_set   = rx_push && (rx_cnt_ff == `FIFO_FULL);
  // Threshold code n means n+1 bytes
  assign rxirq_set = !tmode && rx_push && (rx_cnt_ff >= {1'b0, thr});
  assign txirq_set = tmode && byte_done && (sent_ff == thr) && !rxfl;
  assign uf_set    = load && !tx_avail;
  // Receive flush silences every interrupt
  assign pend_set  = !rxfl && (ovf_set || rxirq_set || txirq_set ||
                     (uf_set && !txfl));

  // Sticky flags; a status read clears only what it reported, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_ff   <= 1'b0;
      rxirq_ff <= 1'b0;
      txirq_ff <= 1'b0;
      uf_ff    <= 1'b0;
      pend_ff  <= 1'b0;
      sent_ff  <= 2'h0;
    end
    else if (clk_en)
    begin
      ovf_ff   <= ovf_set   || (ovf_ff   && !(st_rd && prdata_ff[7]));
      rxirq_ff <= rxirq_set || (rxirq_ff && !(st_rd && prdata_ff[6]));
      txirq_ff <= txirq_set || (txirq_ff && !(st_rd && prdata_ff[5]));
      uf_ff    <= uf_set    || (uf_ff    && !(st_rd && prdata_ff[4]));
      pend_ff  <= pend_set  || (pend_ff  && !(st_rd && prdata_ff[0]));
      if (byte_done)
        sent_ff <= (sent_ff == thr) ? 2'h0 : sent_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------
  // Open-drain MISO drives only low when its enable bit is clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_oe_ff <= 1'b0;
      mosi_ff    <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_ff    <= 1'b0;
      miso_oe_ff <= 1'b0;
      cs_oe_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      sclk_oe_ff <= en && master;
      cs_oe_ff   <= en && master;
      mosi_ff    <= tx_sr_ff[7];
      mosi_oe_ff <= en && master;
      miso_ff    <= tx_sr_ff[7];
      miso_oe_ff <= s_act && (ctrl_ff[`CTL_MISO_EN] || !tx_sr_ff[7]);
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign sclk_out     = sclk_ff;
  assign sclk_oe      = sclk_oe_ff;
  assign mosi_out     = mosi_ff;
  assign mosi_oe      = mosi_oe_ff;
  assign miso_out     = miso_ff;
  assign miso_oe      = miso_oe_ff;
  assign cs_pin_n_out = cs_n_ff;
  assign cs_pin_n_oe  = cs_oe_ff;
endmodule : spi_port

// [hw/spi_port_map.svh]
// Functional notes
// - Full duplex byte, MSB first both lines
// - MISO input as master, driven as slave
// - MOSI driven as master, input as slave
// - SCLK driven as master; eight periods per byte
// - Master SCLK is core clock over 2(1+div)
// - Divider six bits, read/write, resets zero
// - Launch one edge, sample opposite; settings match
// - Slave exchanges bytes while select held low
// - Master drives select low per transfer
// - Excess flag: receive level above threshold
// - Bits 10..8 show receive FIFO level
// - Overflow flag on arrival into full FIFO
// - Receive interrupt in read mode after threshold bytes received
// - Transmit interrupt in transmit mode after threshold bytes sent
// - Underflow flag when sending from empty FIFO
// - Bits 3..1 show transmit FIFO level
// - Pending bit on any interrupt, read clears
// - Receive data read-only, transmit write-only
// - Two-bit threshold selects one to four bytes
// - Receive flush drops data, no interrupts
// - Transmit flush ignores transmit FIFO writes
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
// ----------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------
`define ADDR_STATUS    32'hffff_0a00
`define ADDR_RXDATA    32'hffff_0a04
`define ADDR_TXDATA    32'hffff_0a08
`define ADDR_DIVIDER   32'hffff_0a0c
`define ADDR_CONTROL   32'hffff_0a10
// ----------------------------------------------------------
// Control field positions
// ----------------------------------------------------------
`define CTL_ENABLE     0
`define CTL_MASTER     1
`define CTL_CPHA       2
`define CTL_CPOL       3
`define CTL_TMODE      6
`define CTL_OVERWRITE  8
`define CTL_MISO_EN    9
`define CTL_LOOPBACK   10
`define CTL_CONTINUOUS 11
`define CTL_RX_FLUSH   12
`define CTL_TX_FLUSH   13
`define CTL_THR_HI     15
`define CTL_THR_LO     14
// ----------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------
`define CONTROL_RST    16'h0000
`define DIVIDER_RST    6'h00
`define BYTE_ZERO      8'h00
`define FIFO_FULL      3'h4
`define BIT_LAST       3'h7
`define EDGE_LAST      5'h0f
`define STALL_LAST     5'h01
`endif

// [hw/spi_port_pkg.sv]
package spi_port_pkg;
  // Master sequencer phases
  typedef enum logic [2:0] {M_IDLE, M_LEAD, M_RUN, M_TAIL, M_STALL} master_state_type;
  typedef logic [7:0] byte_type;
endpackage : spi_port_pkg

// [test/spi_port_sva.sv]
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_port_sva (
  input wire logic        pclk, presetn, psel, penable, pwrite,  // Clock, reset, APB
  input wire logic [31:0] paddr, pwdata, prdata,                 // APB address and data
  input wire logic        pready, pslverr,                       // APB answer
  input wire logic        sclk_out, sclk_oe, mosi_oe, miso_oe,   // Serial pins
  input wire logic        cs_pin_n_out, cs_pin_n_oe              // Select pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] div_ff;   // Shadow of the divider
  logic [6:0] gap_ff;   // Cycles since the last serial clock event
  logic [4:0] edge_ff;  // Serial clock edges within one frame
  wire map_hit = paddr inside {`ADDR_STATUS, `ADDR_RXDATA, `ADDR_TXDATA,
                               `ADDR_DIVIDER, `ADDR_CONTROL};
  // ----------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) div_ff <= 6'h00;
    else if (psel && penable && pready && pwrite && paddr == `ADDR_DIVIDER)
      div_ff <= pwdata[5:0];
  // Restart on each edge so the figure is one half period
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) gap_ff <= 7'h00;
    else if ($changed(sclk_out) || $fell(cs_pin_n_out)) gap_ff <= 7'h00;
    else gap_ff <= gap_ff + 7'h01;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) edge_ff <= 5'h00;
    else if ($fell(cs_pin_n_out)) edge_ff <= 5'h00;
    else if ($changed(sclk_out) && !cs_pin_n_out) edge_ff <= edge_ff + 5'h01;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_frame;
    $fell(cs_pin_n_out) && cs_pin_n_oe;
  endsequence
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_map: assert property (pready |-> pslverr == !map_hit)
    else $error("error flag wrong for address");
  a_master_pins: assert property (sclk_oe |-> mosi_oe && !miso_oe)
    else $error("pin directions wrong");
  a_sclk_frame: assert property (sclk_oe && $changed(sclk_out) |-> !cs_pin_n_out)
    else $error("clock moved outside select");
  // The lead-in before the first edge of a byte is not a half period
  a_half_period: assert property (sclk_oe && !cs_pin_n_out && edge_ff[3:0] != 4'h0 &&
    $changed(sclk_out)
    |-> gap_ff == {1'b0, div_ff})
    else $error("half period wrong");
  a_byte_edges: assert property ($rose(cs_pin_n_out) && cs_pin_n_oe |-> edge_ff == 5'h10)
    else $error("edge count wrong");
  a_frame_hold: assert property (s_frame |=> !cs_pin_n_out [*8])
    else $error("select released early");
  a_tx_noread: assert property (pready && !pwrite && paddr == `ADDR_TXDATA
    |-> prdata == 32'h0000_0000)
    else $error("transmit data readable");
  a_div_width: assert property (pready && !pwrite && paddr == `ADDR_DIVIDER
    |-> prdata == {26'h000_0000, div_ff})
    else $error("divider read wrong");
endmodule : spi_port_sva
bind spi_port spi_port_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sclk_out, .sclk_oe, .mosi_oe, .miso_oe,
  .cs_pin_n_out, .cs_pin_n_oe);

// [test/spi_slave_model.sv]
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic sclk,  // Serial clock from master
  input  wire logic cs_n,  // Select, active low
  input  wire logic mosi,  // Data from master
  output logic      miso   // Data to master
);
  logic [7:0] tx_ff, rx_ff;   // Shift registers
  logic [7:0] got [0:15];     // Bytes taken from master
  int cnt = 0;                // Bytes completed
  int nb = 0;                 // Bits of current byte
  initial miso = 1'b0;
  // Reply byte depends on count, MSB first
  always @(negedge cs_n)
  begin
    tx_ff = 8'h50 + cnt[7:0];
    miso = tx_ff[7];
    nb = 0;
  end
  // Sample on leading edge
  always @(posedge sclk)
    if (!cs_n && nb < 8)
    begin
      rx_ff = {rx_ff[6:0], mosi};
      nb++;
      if (nb == 8) got[cnt] = rx_ff;
      if (nb == 8) cnt++;
    end
  // Launch on trailing edge
  always @(negedge sclk)
    if (!cs_n && nb < 8)
    begin
      tx_ff = tx_ff << 1;
      miso = tx_ff[7];
    end
  // Released line must not look like a held bit
  always @(posedge cs_n) miso = ~miso;
endmodule : spi_slave_model

// [test/spi_master_slave_port_bench.sv]
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_master_slave_port_bench;
  logic pclk = 1'b0, presetn = 1'b0;                   // Clock and reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;    // APB request
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rd;
  logic err;                                           // Last error flag
  logic m_sclk = 1'b0, m_cs_n = 1'b1, m_mosi = 1'b1;  // Bench as master
  logic [7:0] sr;                                      // Slave exchange
  int n_errors = 0, check_count = 0, cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe;
  wire miso_out, miso_oe, cs_out, cs_oe, miso_s;
  // Pin levels from all enables; undriven select takes the bench level m_cs_n
  wire sclk_w = sclk_oe ? sclk_out : m_sclk;
  wire mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire cs_w = cs_oe ? cs_out : m_cs_n;
  wire miso_w = miso_oe ? miso_out : miso_s;
  always #5 pclk = ~pclk;
  spi_port i_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sclk_in(sclk_w), .sclk_out, .sclk_oe,
    .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
    .cs_pin_n_in(cs_w), .cs_pin_n_out(cs_out), .cs_pin_n_oe(cs_oe));
  spi_slave_model i_partner (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w), .miso(miso_s));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Request held until pready is seen high at an edge
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // Five writes: the last meets a full queue
  task fill;
    for (int i = 0; i < 5; i++) apb(1'b1, `ADDR_TXDATA, 32'h0000_00a0 + i);
  endtask : fill
  task wait_rx(input int n);
    for (int i = 0; i < 3000 && i_partner.cnt < n; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
  endtask : wait_rx
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("[ERR] %0t run too long", $time);
      close_out();
    end
  end
  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`ADDR_STATUS, 32'h0000_0000);
    rdchk(`ADDR_RXDATA, 32'h0000_0000);
    rdchk(`ADDR_CONTROL, 32'h0000_0000);
    rdchk(`ADDR_DIVIDER, 32'h0000_0000);
    apb(1'b1, `ADDR_DIVIDER, 32'h0000_00ff);
    rdchk(`ADDR_DIVIDER, 32'h0000_003f);
    rdchk(32'hffff_0a20, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, `ADDR_DIVIDER, 32'h0000_0001);
    fill();
    rdchk(`ADDR_STATUS, 32'h0000_0008);
    rdchk(`ADDR_TXDATA, 32'h0000_0000);
    apb(1'b1, `ADDR_CONTROL, 32'h0000_2000);
    apb(1'b1, `ADDR_TXDATA, 32'h0000_0077);
    rdchk(`ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
    fill();
    // Master, sends when queued, threshold of two bytes
    apb(1'b1, `ADDR_CONTROL, 32'h0000_4043);
    wait_rx(4);
    for (int i = 0; i < 4; i++) chk({24'h00_0000, i_partner.got[i]}, 32'h0000_00a0 + i);
    rdchk(`ADDR_STATUS, 32'h0000_0c21);
    rdchk(`ADDR_STATUS, 32'h0000_0c00);
    apb(1'b1, `ADDR_TXDATA, 32'h0000_00a4);
    wait_rx(5);
    rdchk(`ADDR_STATUS, 32'h0000_0c81);
    for (int i = 0; i < 4; i++) rdchk(`ADDR_RXDATA, 32'h0000_0050 + i);
    rdchk(`ADDR_STATUS, 32'h0000_0000);
    // A receive read starts a byte with nothing queued
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0003);
    rdchk(`ADDR_RXDATA, 32'h0000_0000);
    wait_rx(6);
    chk({24'h00_0000, i_partner.got[5]}, 32'h0000_0000);
    rdchk(`ADDR_STATUS, 32'h0000_0151);
    apb(1'b1, `ADDR_CONTROL, 32'h0000_1003);
    rdchk(`ADDR_STATUS, 32'h0000_0000);
    apb(1'b0, `ADDR_RXDATA, 32'h0000_0000);
    wait_rx(7);
    rdchk(`ADDR_STATUS, 32'h0000_0010);
    // Slave: the bench clocks one byte in and out at ten pclk per bit
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0201);
    apb(1'b1, `ADDR_TXDATA, 32'h0000_00c5);
    sr = 8'h3c;
    m_cs_n <= 1'b0;
    repeat (8)
    begin
      m_mosi <= sr[7];
      repeat (5) @(posedge pclk);
      sr = {sr[6:0], miso_w};
      m_sclk <= 1'b1;
      repeat (5) @(posedge pclk);
      m_sclk <= 1'b0;
    end
    m_cs_n <= 1'b1;
    chk({24'h00_0000, sr}, 32'h0000_00c5);
    rdchk(`ADDR_RXDATA, 32'h0000_003c);
    close_out();
  end
endmodule : spi_master_slave_port_bench
